//--- rpss_map.svh
// offsets, field positions, reset values and timing figures of the rom port block
`ifndef RPSS_MAP_SVH
`define RPSS_MAP_SVH

`define RPSS_CLK_HZ 200000000
`define RPSS_SLOW_HZ 30000000
`define RPSS_FAST_HZ 60000000
`define RPSS_HALF_CYC(hz) ((`RPSS_CLK_HZ + 2 * (hz) - 1) / (2 * (hz)))
`define RPSS_HALF_SLOW `RPSS_HALF_CYC(`RPSS_SLOW_HZ)
`define RPSS_HALF_FAST `RPSS_HALF_CYC(`RPSS_FAST_HZ)
`define RPSS_DIV_W 4
`define RPSS_SLOT_CFG_ADDR 8'ha5
`define RPSS_SLOT_FET_LSB 0
`define RPSS_SLOT_FET_MSB 3
`define RPSS_STRAP_RST 1'h0
`define RPSS_PD_RST 1'h1

`endif

//--- rpss_pkg.sv
// types shared by the rom port block
package rpss_pkg;
  typedef enum logic [1:0] {
    RPSS_ST_CAPTURE = 2'b00,
    RPSS_ST_RUN = 2'b01,
    RPSS_ST_SUSPEND = 2'b10
  } rpss_state_t;
  typedef enum logic {
    RPSS_SPD_SLOW = 1'b0,
    RPSS_SPD_FAST = 1'b1
  } rpss_speed_t;
endpackage

//--- rpss_sclk_if.sv
// link between the port controller and the serial clock generator
`timescale 1ns/1ps
interface rpss_sclk_if;
  logic fast;
  logic run;
  logic sclk;
  logic rise;
  modport gen (input fast, input run, output sclk, output rise);
  modport user (output fast, output run, input sclk, input rise);
endinterface

//--- rpss_sclk_gen.sv
// serial rom clock divider, rate picked by the speed strap
`timescale 1ns/1ps
`include "rpss_map.svh"
module rpss_sclk_gen
  import rpss_pkg::*;
#(
  parameter int DIV_W = `RPSS_DIV_W
) (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rst_sync_n,
  // controller side
  rpss_sclk_if.gen sc
);
  localparam logic [DIV_W-1:0] HALF_FAST = DIV_W'(`RPSS_HALF_FAST);
  localparam logic [DIV_W-1:0] HALF_SLOW = DIV_W'(`RPSS_HALF_SLOW);

  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic sclk_q, sclk_d;
  logic [DIV_W-1:0] half;
  logic wrap;

  assign half = sc.fast ? HALF_FAST : HALF_SLOW;
  assign wrap = (cnt_q == half - DIV_W'(1));
  assign cnt_d = (!sc.run || wrap) ? '0 : cnt_q + DIV_W'(1);
  assign sclk_d = sc.run & (wrap ? ~sclk_q : sclk_q);
  assign sc.sclk = sclk_q;
  assign sc.rise = sc.run & wrap & ~sclk_q;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sclk_q <= sclk_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence fast_high_s;
    sc.run && sc.fast && $rose(sclk_q);
  endsequence

  fast_period_a: assert property (fast_high_s ##1 (sc.run && sc.fast) [*2]
      |-> !sclk_q)
    else $error("fast serial clock half period wrong");
  slow_period_a: assert property (sc.run && !sc.fast && $rose(sclk_q) ##1
      (sc.run && !sc.fast) [*3] |-> sclk_q)
    else $error("slow serial clock half period wrong");
  idle_low_a: assert property (!sc.run |=> !sclk_q)
    else $error("serial clock not low when stopped");
endmodule

//--- rpss_rom_port_ctl.sv
// serial rom pin control with reset speed strap, misc output and slot power
`timescale 1ns/1ps
`include "rpss_map.svh"
// Functional notes
// - in reset, data pin undriven, pull-down on
// - latch data pin level at reset release
// - then pin returns to serial data out
// - pull-down off after reset release
// - strap 0 gives 30 MHz, 1 gives 60; the divider yields 25 MHz and 50 MHz
// - strap 1 in suspend floats data pin
// - strap 0 in suspend drives pin low
// - misc pin is an output from logic
// - slot power follows config bits 3..0
// - serial clock low throughout reset
// - chip select active low, high in suspend
module rpss_rom_port_ctl
  import rpss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // chip state and core requests
  input wire logic suspend,
  input wire logic rom_if_enable,
  input wire logic core_rom_select,
  input wire logic core_rom_clk_run,
  input wire logic core_rom_data_out,
  input wire logic core_gpo_value,
  input wire logic [7:0] slot_power_cfg,
  // serial rom pins
  output logic rom_clk_o,
  output logic rom_cs_n_o,
  input wire logic eeprom_data_pin_i,
  output logic eeprom_data_pin_o,
  output logic eeprom_data_pin_oe,
  output logic eeprom_data_pin_pd_en,
  input wire logic rom_data_in_pin,
  // status to the core
  output logic rom_speed_strap,
  output logic rom_data_in,
  output logic rom_clk_rise,
  // misc pins
  output logic general_purpose_output,
  output logic card_slot_power_drive
);
  logic rst_meta_q, rst_sync_q;
  rpss_state_t state_q, state_d;
  logic strap_q, strap_d;
  logic pin_o_q, pin_o_d;
  logic pin_oe_q, pin_oe_d;
  logic pd_q, pd_d;
  logic cs_n_q, cs_n_d;
  logic gpo_q;
  logic slot_q, slot_d;
  logic din_q;
  logic in_capture, in_run, in_susp;

  rpss_sclk_if sc_if ();

  rpss_sclk_gen #(
    .DIV_W(`RPSS_DIV_W)
  ) u_sclk (
    .clk(clk),
    .rst_sync_n(rst_sync_q),
    .sc(sc_if.gen)
  );

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign in_capture = (state_q == RPSS_ST_CAPTURE);
  assign in_run = (state_q == RPSS_ST_RUN);
  assign in_susp = (state_q == RPSS_ST_SUSPEND);

  always_comb begin
    case (state_q)
      RPSS_ST_CAPTURE: state_d = suspend ? RPSS_ST_SUSPEND : RPSS_ST_RUN;
      RPSS_ST_RUN: state_d = suspend ? RPSS_ST_SUSPEND : RPSS_ST_RUN;
      RPSS_ST_SUSPEND: state_d = suspend ? RPSS_ST_SUSPEND : RPSS_ST_RUN;
      default: state_d = RPSS_ST_CAPTURE;
    endcase
  end

  // strap sampled once, in the first cycle after release
  assign strap_d = in_capture ? eeprom_data_pin_i : strap_q;
  assign pin_oe_d = in_run | (in_susp & ~strap_q);
  assign pin_o_d = in_run & core_rom_data_out;
  assign pd_d = 1'b0;
  assign cs_n_d = ~(in_run & rom_if_enable & core_rom_select);
  assign slot_d = |slot_power_cfg[`RPSS_SLOT_FET_MSB:`RPSS_SLOT_FET_LSB];

  assign sc_if.fast = (rpss_speed_t'(strap_q) == RPSS_SPD_FAST);
  assign sc_if.run = in_run & rom_if_enable & core_rom_clk_run;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= RPSS_ST_CAPTURE;
      strap_q <= `RPSS_STRAP_RST;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      pd_q <= `RPSS_PD_RST;
      cs_n_q <= 1'b1;
      gpo_q <= 1'b0;
      slot_q <= 1'b0;
      din_q <= 1'b0;
    end else begin
      state_q <= state_d;
      strap_q <= strap_d;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      pd_q <= pd_d;
      cs_n_q <= cs_n_d;
      gpo_q <= core_gpo_value;
      slot_q <= slot_d;
      din_q <= rom_data_in_pin;
    end
  end

  assign rom_clk_o = sc_if.sclk;
  assign rom_clk_rise = sc_if.rise;
  assign rom_cs_n_o = cs_n_q;
  assign eeprom_data_pin_o = pin_o_q;
  assign eeprom_data_pin_oe = pin_oe_q;
  assign eeprom_data_pin_pd_en = pd_q;
  assign rom_speed_strap = strap_q;
  assign rom_data_in = din_q;
  assign general_purpose_output = gpo_q;
  assign card_slot_power_drive = slot_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_q);

  sequence release_s;
    $rose(rst_sync_q) ##0 in_capture;
  endsequence

  sequence enter_susp_s;
    in_susp && !$past(in_susp);
  endsequence

  capture_float_a: assert property (in_capture |-> !eeprom_data_pin_oe
      && eeprom_data_pin_pd_en)
    else $error("data pin driven or pull-down off while sensing strap");
  strap_latch_a: assert property (rst_sync_q && in_capture |=>
      strap_q == $past(eeprom_data_pin_i))
    else $error("strap not latched from data pin");
  pin_restore_a: assert property (in_capture ##1 in_run |=> eeprom_data_pin_oe)
    else $error("data pin not returned to data out");
  pulldown_off_a: assert property (rst_sync_q && in_capture |=>
      !eeprom_data_pin_pd_en [*2])
    else $error("pull-down left on after release");
  susp_float_a: assert property (enter_susp_s ##0 strap_q |=> !eeprom_data_pin_oe)
    else $error("data pin driven in suspend with fast strap");
  susp_low_a: assert property (in_susp && !strap_q |=> eeprom_data_pin_oe
      && !eeprom_data_pin_o)
    else $error("data pin not driven low in suspend with slow strap");
  slot_power_a: assert property (rst_sync_q |=> card_slot_power_drive ==
      $past(|slot_power_cfg[3:0]))
    else $error("slot power not following config bits");
  cs_suspend_a: assert property (in_susp && rom_if_enable |=> rom_cs_n_o)
    else $error("chip select not high in suspend");
  strap_hold_a: assert property (!in_capture |=> $stable(strap_q))
    else $error("strap changed outside reset release");
  clk_after_rel_a: assert property (release_s |-> !rom_clk_o [*2])
    else $error("serial clock not low out of reset");
  gpo_follow_a: assert property (rst_sync_q |=>
      general_purpose_output == $past(core_gpo_value))
    else $error("misc output not following core value");
endmodule

//--- rpss_rom_model.sv
// serial boot rom stand-in with the strap resistor on the data pin
`timescale 1ns/1ps
module rpss_rom_model (
  // clock and strap choice
  input wire logic clk,
  input wire logic strap_hi,
  // device pins
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic pin_pd_en,
  input wire logic cs_n,
  input wire logic sclk,
  // levels seen by the device
  output logic pin_level,
  output logic data_out
);
  logic last_q = 1'b0;
  logic bit_q = 1'b0;
  always @(posedge clk) if (pin_oe) last_q <= pin_o;
  always @(posedge sclk) bit_q <= ~bit_q;
  // undriven with no pull: inverse of the last driven level
  assign pin_level = pin_oe ? pin_o : strap_hi ? 1'b1 : pin_pd_en ? 1'b0 : ~last_q;
  assign data_out = cs_n ? ~bit_q : bit_q;
endmodule

//--- rom_port_speed_strap_tb_top.sv
// self-checking bench for the rom port pin block
`timescale 1ns/1ps
`include "rpss_map.svh"
module rom_port_speed_strap_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, susp = 1'b0, en = 1'b1, sel = 1'b1, run = 1'b0;
  logic dout = 1'b1, gpo = 1'b0, strap_hi = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic sclk, cs_n, pin, po, poe, ppd, din, dq, strap, gpo_o, slot, rise;
  int err_total = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  rpss_rom_port_ctl uut (.clk(clk), .rst_n(rst_n), .suspend(susp), .rom_if_enable(en),
    .core_rom_select(sel), .core_rom_clk_run(run), .core_rom_data_out(dout),
    .core_gpo_value(gpo), .slot_power_cfg(cfg), .rom_clk_o(sclk), .rom_cs_n_o(cs_n),
    .eeprom_data_pin_i(pin), .eeprom_data_pin_o(po), .eeprom_data_pin_oe(poe),
    .eeprom_data_pin_pd_en(ppd), .rom_data_in_pin(din), .rom_speed_strap(strap),
    .rom_data_in(dq), .rom_clk_rise(rise), .general_purpose_output(gpo_o),
    .card_slot_power_drive(slot));
  rpss_rom_model rom (.clk(clk), .strap_hi(strap_hi), .pin_o(po), .pin_oe(poe),
    .pin_pd_en(ppd), .cs_n(cs_n), .sclk(sclk), .pin_level(pin), .data_out(din));
  task chk(input logic g, input logic e, input string m);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task do_reset(input logic s);
    @(posedge clk) rst_n <= 1'b0;
    strap_hi <= s;
    cyc(3);
    chk(poe, 1'b0, "pin driven in reset");
    chk(ppd, 1'b1, "pull-down off in reset");
    chk(sclk, 1'b0, "clock not low in reset");
    chk(cs_n, 1'b1, "select active in reset");
    @(posedge clk) rst_n <= 1'b1;
    cyc(6);
    chk(strap, s, "strap not latched");
    chk(ppd, 1'b0, "pull-down left on");
    chk(poe, 1'b1, "pin not back to data out");
    chk(po, dout, "data out wrong");
  endtask
  task wr(output int n);
    logic p, r;
    n = 1;
    p = sclk;
    r = rise;
    cyc(1);
    while (!(p === 1'b0 && sclk === 1'b1) && n < 50) begin
      p = sclk;
      r = rise;
      cyc(1);
      n++;
    end
    chk(r, 1'b1, "rise pulse missing before clock edge");
  endtask
  task t_rate(input int half);
    int n;
    logic p;
    @(posedge clk) run <= 1'b1;
    wr(n);
    wr(n);
    chk(n == 2 * half, 1'b1, "serial clock rate");
    p = din;
    cyc(1);
    chk(dq, p, "rom data in not registered");
    @(posedge clk) run <= 1'b0;
    cyc(10);
    chk(sclk, 1'b0, "clock not stopped low");
  endtask
  task t_susp(input logic s);
    @(posedge clk) susp <= 1'b1;
    strap_hi <= ~s;
    cyc(4);
    chk(poe, ~s, "suspend drive choice");
    chk(pin, s ? ~s : 1'b0, "suspend pin level");
    chk(cs_n, 1'b1, "select in suspend");
    chk(strap, s, "strap changed");
    @(posedge clk) susp <= 1'b0;
    cyc(4);
    chk(strap, s, "strap changed on resume");
    chk(cs_n, 1'b0, "select not active in run");
  endtask
  task t_misc();
    for (int i = 0; i < 9; i++) begin
      @(posedge clk) cfg <= (i == 8) ? 8'hf0 : 8'h01 << i;
      gpo <= i[0];
      cyc(3);
      chk(slot, i < 4, "slot power");
      chk(gpo_o, i[0], "misc output");
    end
  endtask
  task t_enable();
    @(posedge clk) en <= 1'b0;
    run <= 1'b1;
    dout <= 1'b0;
    cyc(12);
    chk(cs_n, 1'b1, "select active while disabled");
    chk(sclk, 1'b0, "clock runs while disabled");
    chk(po, 1'b0, "data out not following core");
    @(posedge clk) en <= 1'b1;
    sel <= 1'b0;
    run <= 1'b0;
    dout <= 1'b1;
    cyc(3);
    chk(cs_n, 1'b1, "select active while not selected");
    chk(po, 1'b1, "data out not following core");
    @(posedge clk) sel <= 1'b1;
    cyc(3);
    chk(cs_n, 1'b0, "select not active when selected");
  endtask
  task report_and_stop();
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
  initial begin
    do_reset(1'b0);
    t_rate(`RPSS_HALF_SLOW);
    t_susp(1'b0);
    t_misc();
    t_enable();
    do_reset(1'b1);
    t_rate(`RPSS_HALF_FAST);
    t_susp(1'b1);
    report_and_stop();
  end
endmodule
